// [src/dmbx_exec.sv]
// executor for data-transfer, bit, flag and core-control instructions
`timescale 1ns/1ps
`default_nettype none
module dmbx_exec
#(
	parameter logic [15:0] SP_INIT = dmbx_pkg::SP_RESET  // stack pointer after reset
)
(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	// decoded instruction
	input  wire logic               cmd_valid_i,
	input  wire dmbx_pkg::dmbx_op_t cmd_op_i,
	input  wire logic [4:0]         cmd_reg_i,
	input  wire logic [4:0]         cmd_src_i,
	input  wire logic [15:0]        cmd_addr_i,
	input  wire logic [1:0]         cmd_mode_i,
	input  wire logic [1:0]         cmd_ptr_i,
	input  wire logic [2:0]         cmd_bit_i,
	output logic                    cmd_ready_o,
	output logic                    done_o,
	// data and program memory
	output logic                    mem_req_o,
	output logic                    mem_we_o,
	output logic                    mem_prog_o,
	output logic [15:0]             mem_addr_o,
	output logic [7:0]              mem_wdata_o,
	input  wire logic [7:0]         mem_rdata_i,
	input  wire logic               mem_wait_i,
	input  wire logic               mem_nvm_i,
	// I/O space
	output logic                    io_req_o,
	output logic                    io_we_o,
	output logic [5:0]              io_addr_o,
	output logic [7:0]              io_wdata_o,
	input  wire logic [7:0]         io_rdata_i,
	// side effects for other units
	output logic                    brk_o,
	output logic                    sleep_o,
	output logic                    wdkick_o,
	// visible state
	input  wire logic [4:0]         rf_addr_i,
	output logic [7:0]              rf_data_o,
	output logic [7:0]              status_flags_register_o,
	output logic [15:0]             sp_o
);
	dmbx_pkg::dmbx_core_t r;       // registered state
	dmbx_pkg::dmbx_core_t next_r;  // next state
	dmbx_pkg::dmbx_op_t   cur_op;  // operation being worked, live in idle
	logic [4:0]           cur_reg; // register operand
	logic [4:0]           cur_src; // second register operand
	logic [15:0]          cur_addr;
	logic [1:0]           cur_mode;
	logic [1:0]           cur_psel;
	logic [2:0]           cur_bit;
	logic [4:0]           ptr_lo;  // index of pointer low byte
	logic [15:0]          ptr;     // selected pointer value
	logic [15:0]          ptr_new; // pointer after update
	logic                 ptr_upd; // pointer gets written
	logic [15:0]          ea;      // effective data address
	logic                 is_mem;  // op uses memory port
	logic                 is_wr;   // memory write
	logic                 is_prog; // program memory read
	logic                 exec;    // working cycle of the op
	logic                 finish;  // op completes this cycle
	logic [1:0]           cycles;  // listed cycle count of cmd_op_i
	logic [7:0]           rval;    // register operand value
	logic [7:0]           bmask;   // one-hot bit mask
	logic [7:0]           sh_res;
	logic                 sh_c;
	logic                 sh_z;
	logic                 sh_n;
	logic                 sh_v;
	logic                 sh_h;

	// operands come straight from the command in idle, from latches later
	always_comb
	begin
		if (r.state == dmbx_pkg::ST_IDLE)
		begin
			cur_op   = cmd_op_i;
			cur_reg  = cmd_reg_i;
			cur_src  = cmd_src_i;
			cur_addr = cmd_addr_i;
			cur_mode = cmd_mode_i;
			cur_psel = cmd_ptr_i;
			cur_bit  = cmd_bit_i;
		end
		else
		begin
			cur_op   = r.op;
			cur_reg  = r.rsel;
			cur_src  = r.ssel;
			cur_addr = r.addr;
			cur_mode = r.mode;
			cur_psel = r.psel;
			cur_bit  = r.bsel;
		end
	end

	// instruction length for internal RAM
	always_comb
	begin
		case (cmd_op_i)
			dmbx_pkg::OP_DIRECT_LOAD:         cycles = dmbx_pkg::CYC_DIRECT_LOAD;
			dmbx_pkg::OP_INDIRECT_LOAD:       cycles = dmbx_pkg::CYC_PTR_LOAD;
			dmbx_pkg::OP_DISPLACED_LOAD:      cycles = dmbx_pkg::CYC_PTR_LOAD;
			dmbx_pkg::OP_PROGRAM_MEMORY_READ: cycles = dmbx_pkg::CYC_PROG_READ;
			dmbx_pkg::OP_POP:                 cycles = dmbx_pkg::CYC_POP;
			default:                          cycles = dmbx_pkg::CYC_SINGLE;
		endcase
	end

	// address generation; program reads always use Z
	always_comb
	begin
		ptr_lo  = dmbx_pkg::PTR_BASE
			+ {2'h0, ((cur_op == dmbx_pkg::OP_PROGRAM_MEMORY_READ) ? dmbx_pkg::PTR_Z : cur_psel), 1'b0};
		ptr     = {r.regs[ptr_lo + 5'h01], r.regs[ptr_lo]};
		ptr_upd = 1'b0;
		// 16-bit arithmetic wraps naturally, flags are never involved
		ptr_new = (cur_mode == dmbx_pkg::MODE_PREDEC) ? ptr - 16'h0001 : ptr + 16'h0001;
		is_mem  = 1'b1;
		is_wr   = 1'b0;
		is_prog = 1'b0;
		ea      = ptr;
		case (cur_op)
			dmbx_pkg::OP_DIRECT_LOAD:
				ea = cur_addr;
			dmbx_pkg::OP_DIRECT_STORE:
			begin
				ea    = cur_addr;
				is_wr = 1'b1;
			end
			dmbx_pkg::OP_INDIRECT_LOAD, dmbx_pkg::OP_INDIRECT_STORE:
			begin
				is_wr   = (cur_op == dmbx_pkg::OP_INDIRECT_STORE);
				ptr_upd = (cur_mode == dmbx_pkg::MODE_POSTINC) || (cur_mode == dmbx_pkg::MODE_PREDEC);
				// decremented value is the address used
				ea      = (cur_mode == dmbx_pkg::MODE_PREDEC) ? ptr_new : ptr;
			end
			dmbx_pkg::OP_DISPLACED_LOAD, dmbx_pkg::OP_DISPLACED_STORE:
			begin
				is_wr = (cur_op == dmbx_pkg::OP_DISPLACED_STORE);
				ea    = ptr + {10'h000, cur_addr[5:0]};
			end
			dmbx_pkg::OP_PROGRAM_MEMORY_READ:
			begin
				is_prog = 1'b1;
				ptr_upd = (cur_mode == dmbx_pkg::MODE_POSTINC);
			end
			dmbx_pkg::OP_PUSH:
			begin
				ea    = r.sp;
				is_wr = 1'b1;
			end
			dmbx_pkg::OP_POP:
				ea = r.sp + 16'h0001;
			default:
				is_mem = 1'b0;
		endcase
	end

	assign rval  = r.regs[cur_reg];
	assign bmask = 8'h01 << cur_bit;

	// shift and rotate datapath
	dmbx_shift_unit u_shift
	(
		.op_i    (cur_op),
		.val_i   (rval),
		.carry_i (r.flags[dmbx_pkg::FLAG_C]),
		.res_o   (sh_res),
		.c_o     (sh_c),
		.z_o     (sh_z),
		.n_o     (sh_n),
		.v_o     (sh_v),
		.h_o     (sh_h)
	);

	// sequencer and all register, flag and pointer updates
	always_comb
	begin
		next_r      = r;
		exec        = 1'b0;
		finish      = 1'b0;
		mem_req_o   = 1'b0;
		io_req_o    = 1'b0;
		io_we_o     = 1'b0;
		io_wdata_o  = rval;
		brk_o       = 1'b0;
		sleep_o     = 1'b0;
		wdkick_o    = 1'b0;
		next_r.rd_data = r.regs[rf_addr_i];
		case (r.state)
			dmbx_pkg::ST_IDLE:
			begin
				if (cmd_valid_i)
				begin
					next_r.op   = cmd_op_i;
					next_r.rsel = cmd_reg_i;
					next_r.ssel = cmd_src_i;
					next_r.addr = cmd_addr_i;
					next_r.mode = cmd_mode_i;
					next_r.psel = cmd_ptr_i;
					next_r.bsel = cmd_bit_i;
					if (cycles > dmbx_pkg::CYC_SINGLE)
					begin
						next_r.state = dmbx_pkg::ST_WAIT;
						next_r.cnt   = cycles - 2'h2;
					end
					else
						exec = 1'b1;
				end
			end
			dmbx_pkg::ST_WAIT:
			begin
				// the access itself happens in the last listed cycle
				if (r.cnt == 2'h0)
					exec = 1'b1;
				else
					next_r.cnt = r.cnt - 2'h1;
			end
			dmbx_pkg::ST_ACCESS:
				exec = 1'b1;
			default:
				next_r.state = dmbx_pkg::ST_IDLE;
		endcase
		if (exec)
		begin
			mem_req_o = is_mem;
			// nonvolatile route costs data accesses one cycle more (program reads none), wait may stretch further
			finish = !is_mem || (!mem_wait_i && (is_prog || !mem_nvm_i || r.xtra));
			if (!finish)
			begin
				next_r.state = dmbx_pkg::ST_ACCESS;
				next_r.xtra  = r.xtra | mem_nvm_i;
			end
			else
			begin
				next_r.state = dmbx_pkg::ST_IDLE;
				next_r.xtra  = 1'b0;
				if (ptr_upd)
				begin
					next_r.regs[ptr_lo]         = ptr_new[7:0];
					next_r.regs[ptr_lo + 5'h01] = ptr_new[15:8];
				end
				case (cur_op)
					dmbx_pkg::OP_BREAK:        brk_o = 1'b1;
					dmbx_pkg::OP_SLEEP:        sleep_o = 1'b1;
					dmbx_pkg::OP_WATCHDOG_KICK: wdkick_o = 1'b1;
					dmbx_pkg::OP_LOAD_IMM:     next_r.regs[cur_reg] = cur_addr[7:0];
					dmbx_pkg::OP_MOVE:         next_r.regs[cur_reg] = r.regs[cur_src];
					dmbx_pkg::OP_DIRECT_LOAD, dmbx_pkg::OP_INDIRECT_LOAD, dmbx_pkg::OP_DISPLACED_LOAD:
						next_r.regs[cur_reg] = mem_rdata_i;
					dmbx_pkg::OP_PROGRAM_MEMORY_READ:
						next_r.regs[cur_reg] = mem_rdata_i;
					dmbx_pkg::OP_PUSH:
						next_r.sp = r.sp - 16'h0001;
					dmbx_pkg::OP_POP:
					begin
						next_r.sp            = r.sp + 16'h0001;
						next_r.regs[cur_reg] = mem_rdata_i;
					end
					dmbx_pkg::OP_IO_READ:
					begin
						io_req_o             = 1'b1;
						next_r.regs[cur_reg] = io_rdata_i;
					end
					dmbx_pkg::OP_IO_WRITE:
					begin
						io_req_o = 1'b1;
						io_we_o  = 1'b1;
					end
					dmbx_pkg::OP_IO_BIT_SET, dmbx_pkg::OP_IO_BIT_CLEAR:
					begin
						// read-modify-write in the same cycle keeps the other bits
						io_req_o   = 1'b1;
						io_we_o    = 1'b1;
						io_wdata_o = (cur_op == dmbx_pkg::OP_IO_BIT_SET) ? (io_rdata_i | bmask)
							: (io_rdata_i & ~bmask);
					end
					dmbx_pkg::OP_LOGICAL_SHIFT_UP, dmbx_pkg::OP_CARRY_ROTATE_LEFT:
					begin
						next_r.regs[cur_reg] = sh_res;
						next_r.flags[dmbx_pkg::FLAG_H] = sh_h;
						next_r.flags[dmbx_pkg::FLAG_C] = sh_c;
						next_r.flags[dmbx_pkg::FLAG_Z] = sh_z;
						next_r.flags[dmbx_pkg::FLAG_N] = sh_n;
						next_r.flags[dmbx_pkg::FLAG_V] = sh_v;
					end
					dmbx_pkg::OP_LOGICAL_SHIFT_DOWN, dmbx_pkg::OP_CARRY_ROTATE_RIGHT,
					dmbx_pkg::OP_SIGNED_SHIFT_DOWN:
					begin
						next_r.regs[cur_reg] = sh_res;
						next_r.flags[dmbx_pkg::FLAG_C] = sh_c;
						next_r.flags[dmbx_pkg::FLAG_Z] = sh_z;
						next_r.flags[dmbx_pkg::FLAG_N] = sh_n;
						next_r.flags[dmbx_pkg::FLAG_V] = sh_v;
					end
					dmbx_pkg::OP_BIT_TO_FLAG_COPY:
						next_r.flags[dmbx_pkg::FLAG_T] = rval[cur_bit];
					dmbx_pkg::OP_FLAG_TO_BIT_COPY:
						next_r.regs[cur_reg][cur_bit] = r.flags[dmbx_pkg::FLAG_T];
					dmbx_pkg::OP_INDEXED_FLAG_SET:   next_r.flags[cur_bit] = 1'b1;
					dmbx_pkg::OP_INDEXED_FLAG_CLEAR: next_r.flags[cur_bit] = 1'b0;
					dmbx_pkg::OP_GLOBAL_IRQ_ON:      next_r.flags[dmbx_pkg::FLAG_I] = 1'b1;
					dmbx_pkg::OP_GLOBAL_IRQ_OFF:     next_r.flags[dmbx_pkg::FLAG_I] = 1'b0;
					default:
					begin
					end
				endcase
			end
		end
	end

	// state register, sync reset
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			r       <= '0;
			r.state <= dmbx_pkg::ST_IDLE;
			r.op    <= dmbx_pkg::OP_IDLE_INSTR;
			r.flags <= dmbx_pkg::FLAGS_RESET;
			r.sp    <= SP_INIT;
		end
		else
			r <= next_r;
	end

	// port drives; memory strobes follow the working cycle
	assign cmd_ready_o = (r.state == dmbx_pkg::ST_IDLE);
	assign done_o      = exec && finish;
	assign mem_we_o    = mem_req_o && is_wr;
	assign mem_prog_o  = mem_req_o && is_prog;
	assign mem_addr_o  = is_prog ? ptr : ea;
	assign mem_wdata_o = rval;
	assign io_addr_o   = cur_addr[5:0];
	assign rf_data_o   = r.rd_data;
	assign status_flags_register_o      = r.flags;
	assign sp_o        = r.sp;

	// checks on timing and side effects
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic acc;
	assign acc = cmd_valid_i && cmd_ready_o;
	sequence s_prog_start;
		acc && cmd_op_i == dmbx_pkg::OP_PROGRAM_MEMORY_READ;
	endsequence
	sequence s_prog_access;
		!mem_req_o ##1 !mem_req_o ##1 mem_prog_o;
	endsequence

	direct_load_time_a:
	assert property (acc && cmd_op_i == dmbx_pkg::OP_DIRECT_LOAD |-> !mem_req_o ##2 (mem_req_o && !mem_we_o))
		else $error("direct load access not in third cycle");
	direct_store_now_a:
	assert property (acc && cmd_op_i == dmbx_pkg::OP_DIRECT_STORE |-> mem_we_o && mem_addr_o == cmd_addr_i)
		else $error("direct store not issued in first cycle");
	ptr_load_time_a:
	assert property (acc && cmd_op_i == dmbx_pkg::OP_INDIRECT_LOAD |-> !mem_req_o ##1 mem_req_o)
		else $error("indirect load access not in second cycle");
	prog_read_time_a:
	assert property (s_prog_start |-> s_prog_access)
		else $error("program read access not in third cycle");
	push_stack_a:
	assert property (acc && cmd_op_i == dmbx_pkg::OP_PUSH && !mem_wait_i && !mem_nvm_i
		|-> mem_we_o && mem_addr_o == sp_o ##1 sp_o == $past(sp_o) - 16'h0001)
		else $error("push address or stack pointer wrong");
	pop_stack_a:
	assert property (acc && cmd_op_i == dmbx_pkg::OP_POP |-> ##1 mem_req_o && mem_addr_o == sp_o + 16'h0001)
		else $error("pop address wrong");
	nvm_extra_a:
	assert property (mem_req_o && !mem_prog_o && mem_nvm_i && !r.xtra |-> !done_o ##1 mem_req_o)
		else $error("nonvolatile access finished without extra cycle");
	wait_hold_a:
	assert property (mem_req_o && mem_wait_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("stalled access dropped");
	io_bit_set_a:
	assert property (acc && cmd_op_i == dmbx_pkg::OP_IO_BIT_SET
		|-> io_we_o && io_wdata_o == (io_rdata_i | (8'h01 << cmd_bit_i)))
		else $error("io bit set wrote wrong value");
	quiet_flags_a:
	assert property (acc && cmd_op_i == dmbx_pkg::OP_IDLE_INSTR |-> done_o ##1 $stable(status_flags_register_o))
		else $error("idle instruction changed flags");
endmodule
`default_nettype wire

// [src/dmbx_pkg.sv]
// shared types and constants for the data-move and bit-operation executor
package dmbx_pkg;
	// decoded instruction selector
	typedef enum logic [4:0] {
		OP_IDLE_INSTR, OP_BREAK, OP_SLEEP, OP_WATCHDOG_KICK,
		OP_LOAD_IMM, OP_MOVE, OP_DIRECT_LOAD, OP_DIRECT_STORE,
		OP_INDIRECT_LOAD, OP_INDIRECT_STORE, OP_DISPLACED_LOAD, OP_DISPLACED_STORE,
		OP_PROGRAM_MEMORY_READ, OP_IO_READ, OP_IO_WRITE, OP_PUSH, OP_POP,
		OP_LOGICAL_SHIFT_UP, OP_CARRY_ROTATE_LEFT, OP_LOGICAL_SHIFT_DOWN,
		OP_CARRY_ROTATE_RIGHT, OP_SIGNED_SHIFT_DOWN, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
		OP_BIT_TO_FLAG_COPY, OP_FLAG_TO_BIT_COPY, OP_INDEXED_FLAG_SET,
		OP_INDEXED_FLAG_CLEAR, OP_GLOBAL_IRQ_ON, OP_GLOBAL_IRQ_OFF
	} dmbx_op_t;
	// sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACCESS} dmbx_state_t;
	// pointer addressing modes
	localparam logic [1:0] MODE_PLAIN   = 2'h0;
	localparam logic [1:0] MODE_POSTINC = 2'h1;
	localparam logic [1:0] MODE_PREDEC  = 2'h2;
	// pointer pair selectors
	localparam logic [1:0] PTR_X = 2'h0;
	localparam logic [1:0] PTR_Y = 2'h1;
	localparam logic [1:0] PTR_Z = 2'h2;
	localparam logic [4:0] PTR_BASE = 5'h1a;  // low byte of X
	localparam logic [4:0] REG_ZERO = 5'h00;  // default target of program read
	// status flag positions
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;
	// cycle counts for internal RAM
	localparam logic [1:0] CYC_DIRECT_LOAD = 2'h3;
	localparam logic [1:0] CYC_PTR_LOAD    = 2'h2;
	localparam logic [1:0] CYC_PROG_READ   = 2'h3;
	localparam logic [1:0] CYC_POP         = 2'h2;
	localparam logic [1:0] CYC_SINGLE      = 2'h1;
	// reset values
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [15:0] SP_RESET    = 16'h00ff;
	// whole state of the executor
	typedef struct packed {
		dmbx_state_t     state;   // sequencer state
		logic [1:0]      cnt;     // wait cycles left
		logic            xtra;    // nonvolatile extra cycle spent
		dmbx_op_t        op;      // latched instruction
		logic [4:0]      rsel;    // latched register
		logic [4:0]      ssel;    // latched second register
		logic [15:0]     addr;    // latched address/offset/immediate
		logic [1:0]      mode;    // latched pointer mode
		logic [1:0]      psel;    // latched pointer pair
		logic [2:0]      bsel;    // latched bit index
		logic [7:0]      flags;   // status flags register
		logic [15:0]     sp;      // stack pointer
		logic [7:0]      rd_data; // register read port
		logic [31:0][7:0] regs;   // working registers
	} dmbx_core_t;
endpackage

// [src/dmbx_shift_unit.sv]
// shift and rotate unit with its flag results
`timescale 1ns/1ps
`default_nettype none
module dmbx_shift_unit
(
	// operation
	input  wire dmbx_pkg::dmbx_op_t op_i,
	input  wire logic [7:0]         val_i,
	input  wire logic               carry_i,
	// results
	output logic [7:0]              res_o,
	output logic                    c_o,
	output logic                    z_o,
	output logic                    n_o,
	output logic                    v_o,
	output logic                    h_o
);
	// one mux covers all five forms, which differ in shift direction and fill bit
	always_comb
	begin
		res_o = val_i;
		c_o   = 1'b0;
		h_o   = val_i[3];  // left forms report bit 3 carry into high nibble
		case (op_i)
			dmbx_pkg::OP_LOGICAL_SHIFT_UP:
			begin
				res_o = {val_i[6:0], 1'b0};
				c_o   = val_i[7];
			end
			dmbx_pkg::OP_CARRY_ROTATE_LEFT:
			begin
				res_o = {val_i[6:0], carry_i};
				c_o   = val_i[7];
			end
			dmbx_pkg::OP_LOGICAL_SHIFT_DOWN:
			begin
				res_o = {1'b0, val_i[7:1]};
				c_o   = val_i[0];
			end
			dmbx_pkg::OP_CARRY_ROTATE_RIGHT:
			begin
				res_o = {carry_i, val_i[7:1]};
				c_o   = val_i[0];
			end
			dmbx_pkg::OP_SIGNED_SHIFT_DOWN:
			begin
				res_o = {val_i[7], val_i[7:1]};
				c_o   = val_i[0];
			end
			default:
			begin
				res_o = val_i;
			end
		endcase
		n_o = res_o[7];
		z_o = (res_o == 8'h00);
		v_o = n_o ^ c_o;  // overflow is defined as N xor C for shifts
	end
endmodule
`default_nettype wire

// [bench/dmbx_mem_model.sv]
// data memory, program memory and I/O space seen from the executor
`timescale 1ns/1ps
`default_nettype none
module dmbx_mem_model
(
	// clock
	input  wire logic        clk_i,
	// memory side
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic        prog_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        stall_i,
	output logic [7:0]       rdata_o,
	output logic             wait_o,
	output logic             nvm_o,
	// I/O side
	input  wire logic        io_req_i,
	input  wire logic        io_we_i,
	input  wire logic [5:0]  io_addr_i,
	input  wire logic [7:0]  io_wdata_i,
	output logic [7:0]       io_rdata_o
);
	logic [7:0] ram [256]; // data bytes, low address byte only
	logic [7:0] io [64];   // I/O locations
	logic [7:0] last;      // last byte shown; idle bus shows its inverse
	// page 0x80 is routed through the nonvolatile controller
	assign nvm_o = req_i & (addr_i[15:8] == 8'h80);
	assign wait_o = req_i & stall_i;
	// program bytes are a fixed pattern so no stale value can pass
	assign rdata_o = !req_i ? ~last : prog_i ? (addr_i[7:0] ^ 8'h5a) : ram[addr_i[7:0]];
	assign io_rdata_o = io_req_i ? io[io_addr_i] : ~last;
	// writes land at every unstalled edge; a repeated write is harmless
	always @(posedge clk_i)
	begin
		if (req_i & we_i & !stall_i)
			ram[addr_i[7:0]] <= wdata_i;
		if (io_req_i & io_we_i)
			io[io_addr_i] <= io_wdata_i;
		if (req_i)
			last <= rdata_o;
	end
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking testbench for the data-move and bit-operation executor
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic               clk_i, sys_rst_i, cv, stall; // clock, reset, request, stall
	dmbx_pkg::dmbx_op_t op;                          // operation
	logic [4:0]         rg, rfa;                     // operand, debug read address
	logic [15:0]        ad, mad, sp, w;              // address field, bus, stack, pointer
	logic [1:0]         md, pt;                      // pointer mode and pair
	logic [2:0]         bt, seen;                    // bit index, pulses seen
	logic               rdy, dn, mrq, mwe, mpg, mwt, mnv, irq, iwe, brk, slp, wdk;
	logic [7:0]         mwd, mrd, iwd, ird, rfd, status_flags_register, v;
	logic [5:0]         iad;
	int                 miscompares, num_checks, n;
	dmbx_exec DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cv), .cmd_op_i(op),
		.cmd_reg_i(rg), .cmd_src_i(5'h00), .cmd_addr_i(ad), .cmd_mode_i(md), .cmd_ptr_i(pt),
		.cmd_bit_i(bt), .cmd_ready_o(rdy), .done_o(dn), .mem_req_o(mrq), .mem_we_o(mwe),
		.mem_prog_o(mpg), .mem_addr_o(mad), .mem_wdata_o(mwd), .mem_rdata_i(mrd),
		.mem_wait_i(mwt), .mem_nvm_i(mnv), .io_req_o(irq), .io_we_o(iwe), .io_addr_o(iad),
		.io_wdata_o(iwd), .io_rdata_i(ird), .brk_o(brk), .sleep_o(slp), .wdkick_o(wdk),
		.rf_addr_i(rfa), .rf_data_o(rfd), .status_flags_register_o(status_flags_register), .sp_o(sp));
	dmbx_mem_model mem (.clk_i(clk_i), .req_i(mrq), .we_i(mwe), .prog_i(mpg), .addr_i(mad),
		.wdata_i(mwd), .stall_i(stall), .rdata_o(mrd), .wait_o(mwt), .nvm_o(mnv),
		.io_req_i(irq), .io_we_i(iwe), .io_addr_i(iad), .io_wdata_i(iwd), .io_rdata_o(ird));
	// clock at 25 ns
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// sticky record of side-effect pulses
	always @(posedge clk_i)
		seen <= sys_rst_i ? 3'h0 : seen | {wdk, slp, brk};
	// value compare
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %0t value %h expected %h", $time, got, exp);
		end
	endtask
	// cycle count compare
	task automatic cyc(input int got, input int exp);
		num_checks++;
		if (got != exp)
		begin
			miscompares++;
			$display("FAIL %0t took %0d cycles expected %0d", $time, got, exp);
		end
	endtask
	// one instruction: held for one cycle, n counts cycles up to done
	task automatic run(input dmbx_pkg::dmbx_op_t o, input logic [4:0] r, input logic [15:0] a,
		input logic [1:0] m, input logic [1:0] p, input logic [2:0] b);
		@(posedge clk_i);
		cv <= 1'b1;
		op <= o;
		rg <= r;
		ad <= a;
		md <= m;
		pt <= p;
		bt <= b;
		n = 1;
		@(negedge clk_i);
		// bounded so a missing done cannot hang the run
		while (dn !== 1'b1 && n < 50)
		begin
			@(posedge clk_i);
			cv <= 1'b0;
			n++;
			@(negedge clk_i);
		end
		@(posedge clk_i);
		cv <= 1'b0;
		@(negedge clk_i);
	endtask
	// debug read of one register, one cycle latency
	task automatic rreg(input logic [4:0] r);
		@(posedge clk_i);
		rfa <= r;
		@(posedge clk_i);
		@(negedge clk_i);
		v = rfd;
	endtask
	// immediate load
	task automatic li(input logic [4:0] r, input logic [7:0] k);
		run(dmbx_pkg::OP_LOAD_IMM, r, {8'h00, k}, 2'h0, 2'h0, 3'h0);
	endtask
	// pointer pair read and write
	task automatic rptr(input logic [1:0] p);
		rreg(dmbx_pkg::PTR_BASE + 5'(2 * p) + 5'h01);
		w[15:8] = v;
		rreg(dmbx_pkg::PTR_BASE + 5'(2 * p));
		w[7:0] = v;
	endtask
	task automatic setp(input logic [1:0] p, input logic [15:0] k);
		li(dmbx_pkg::PTR_BASE + 5'(2 * p), k[7:0]);
		li(dmbx_pkg::PTR_BASE + 5'(2 * p) + 5'h01, k[15:8]);
	endtask
	// direct access in RAM, through the nonvolatile path, and stalled
	task automatic t_direct;
		li(5'h10, 8'ha5);
		run(dmbx_pkg::OP_DIRECT_STORE, 5'h10, 16'h0040, 2'h0, 2'h0, 3'h0);
		cyc(n, 1);
		run(dmbx_pkg::OP_DIRECT_LOAD, 5'h11, 16'h0040, 2'h0, 2'h0, 3'h0);
		cyc(n, 3);
		rreg(5'h11);
		cmp(v, 8'ha5);
		run(dmbx_pkg::OP_DIRECT_STORE, 5'h10, 16'h8041, 2'h0, 2'h0, 3'h0);
		cyc(n, 2);
		@(posedge clk_i);
		stall <= 1'b1;
		fork
			run(dmbx_pkg::OP_DIRECT_LOAD, 5'h12, 16'h8041, 2'h0, 2'h0, 3'h0);
			begin
				repeat (3) @(posedge clk_i);
				@(negedge clk_i);
				cmp(rdy, 1'b0);
				repeat (3) @(posedge clk_i);
				stall <= 1'b0;
			end
		join
		cmp(n > 4, 1'b1);
		rreg(5'h12);
		cmp(v, 8'ha5);
		cmp(status_flags_register, 8'h00);
		$display("direct access test done");
	endtask
	// pointer modes, displacement and 16-bit wrap
	task automatic t_ptr;
		setp(dmbx_pkg::PTR_X, 16'hffff);
		run(dmbx_pkg::OP_INDIRECT_STORE, 5'h10, 16'h0, dmbx_pkg::MODE_POSTINC, dmbx_pkg::PTR_X, 3'h0);
		cyc(n, 1);
		rptr(dmbx_pkg::PTR_X);
		cmp(w, 16'h0000);
		run(dmbx_pkg::OP_INDIRECT_LOAD, 5'h13, 16'h0, dmbx_pkg::MODE_PREDEC, dmbx_pkg::PTR_X, 3'h0);
		cyc(n, 2);
		rreg(5'h13);
		cmp(v, 8'ha5);
		rptr(dmbx_pkg::PTR_X);
		cmp(w, 16'hffff);
		setp(dmbx_pkg::PTR_Y, 16'h0030);
		setp(dmbx_pkg::PTR_Z, 16'h0030);
		li(5'h0e, 8'h3c);
		run(dmbx_pkg::OP_DISPLACED_STORE, 5'h0e, 16'h5, dmbx_pkg::MODE_PLAIN, dmbx_pkg::PTR_Y, 3'h0);
		cyc(n, 1);
		run(dmbx_pkg::OP_DISPLACED_LOAD, 5'h15, 16'h5, dmbx_pkg::MODE_PLAIN, dmbx_pkg::PTR_Z, 3'h0);
		cyc(n, 2);
		rreg(5'h15);
		cmp(v, 8'h3c);
		rptr(dmbx_pkg::PTR_Z);
		cmp(w, 16'h0030);
		run(dmbx_pkg::OP_INDIRECT_STORE, 5'h10, 16'h0, dmbx_pkg::MODE_PREDEC, dmbx_pkg::PTR_Y, 3'h0);
		cyc(n, 1);
		run(dmbx_pkg::OP_INDIRECT_LOAD, 5'h16, 16'h0, dmbx_pkg::MODE_POSTINC, dmbx_pkg::PTR_Y, 3'h0);
		cyc(n, 2);
		rreg(5'h16);
		cmp(v, 8'ha5);
		rptr(dmbx_pkg::PTR_Y);
		cmp(w, 16'h0030);
		run(dmbx_pkg::OP_INDIRECT_LOAD, 5'h0d, 16'h0, dmbx_pkg::MODE_PLAIN, dmbx_pkg::PTR_X, 3'h0);
		cyc(n, 2);
		rreg(5'h0d);
		cmp(v, 8'ha5);
		rptr(dmbx_pkg::PTR_X);
		cmp(w, 16'hffff);
		$display("pointer test done");
	endtask
	// program read, I/O moves and bit edits, stack
	task automatic t_misc;
		setp(dmbx_pkg::PTR_Z, 16'h1234);
		run(dmbx_pkg::OP_PROGRAM_MEMORY_READ, dmbx_pkg::REG_ZERO, 16'h0, dmbx_pkg::MODE_POSTINC,
			dmbx_pkg::PTR_Z, 3'h0);
		cyc(n, 3);
		rreg(dmbx_pkg::REG_ZERO);
		cmp(v, 8'h34 ^ 8'h5a);
		rptr(dmbx_pkg::PTR_Z);
		cmp(w, 16'h1235);
		run(dmbx_pkg::OP_IO_WRITE, 5'h10, 16'h5, 2'h0, 2'h0, 3'h0);
		cyc(n, 1);
		run(dmbx_pkg::OP_IO_BIT_SET, 5'h00, 16'h5, 2'h0, 2'h0, 3'h1);
		run(dmbx_pkg::OP_IO_BIT_CLEAR, 5'h00, 16'h5, 2'h0, 2'h0, 3'h0);
		cyc(n, 1);
		run(dmbx_pkg::OP_IO_READ, 5'h17, 16'h5, 2'h0, 2'h0, 3'h0);
		cyc(n, 1);
		rreg(5'h17);
		cmp(v, 8'ha6);
		run(dmbx_pkg::OP_PUSH, 5'h10, 16'h0, 2'h0, 2'h0, 3'h0);
		cyc(n, 1);
		cmp(sp, 16'h00fe);
		run(dmbx_pkg::OP_POP, 5'h18, 16'h0, 2'h0, 2'h0, 3'h0);
		cyc(n, 2);
		cmp(sp, 16'h00ff);
		rreg(5'h18);
		cmp(v, 8'ha5);
		cmp(status_flags_register, 8'h00);
		$display("program, I/O and stack test done");
	endtask
	// each flag alone, bit copies, core-control ops
	task automatic t_flags;
		for (int i = 0; i < 8; i++)
		begin
			run(dmbx_pkg::OP_INDEXED_FLAG_SET, 5'h00, 16'h0, 2'h0, 2'h0, 3'(i));
			cmp(status_flags_register, 16'(8'h01 << i));
			run(dmbx_pkg::OP_INDEXED_FLAG_CLEAR, 5'h00, 16'h0, 2'h0, 2'h0, 3'(i));
			cmp(status_flags_register, 8'h00);
		end
		run(dmbx_pkg::OP_GLOBAL_IRQ_ON, 5'h00, 16'h0, 2'h0, 2'h0, 3'h0);
		cmp(status_flags_register, 8'h80);
		run(dmbx_pkg::OP_GLOBAL_IRQ_OFF, 5'h00, 16'h0, 2'h0, 2'h0, 3'h0);
		run(dmbx_pkg::OP_BIT_TO_FLAG_COPY, 5'h10, 16'h0, 2'h0, 2'h0, 3'h2);
		cmp(status_flags_register, 8'h40);
		li(5'h19, 8'h00);
		run(dmbx_pkg::OP_FLAG_TO_BIT_COPY, 5'h19, 16'h0, 2'h0, 2'h0, 3'h3);
		cyc(n, 1);
		rreg(5'h19);
		cmp(v, 8'h08);
		for (int i = 0; i < 4; i++)
		begin
			run(dmbx_pkg::dmbx_op_t'(i), 5'h00, 16'h0, 2'h0, 2'h0, 3'h0);
			cyc(n, 1);
			cmp(status_flags_register, 8'h40);
		end
		cmp(seen, 3'h7);
		$display("flag and control test done");
	endtask
	// shifts on 8'h89, carry set, half-carry clear; flags as {H,V,N,Z,C}
	// bit 3 set so right shifts that wrongly update half-carry show up
	task automatic t_shift;
		dmbx_pkg::dmbx_op_t ops [5] = '{dmbx_pkg::OP_LOGICAL_SHIFT_UP, dmbx_pkg::OP_CARRY_ROTATE_LEFT,
			dmbx_pkg::OP_LOGICAL_SHIFT_DOWN, dmbx_pkg::OP_CARRY_ROTATE_RIGHT, dmbx_pkg::OP_SIGNED_SHIFT_DOWN};
		logic [7:0] res [5] = '{8'h12, 8'h13, 8'h44, 8'hc4, 8'hc4};
		logic [4:0] fl [5] = '{5'h19, 5'h19, 5'h09, 5'h05, 5'h05};
		for (int i = 0; i < 5; i++)
		begin
			li(5'h14, 8'h89);
			run(dmbx_pkg::OP_INDEXED_FLAG_SET, 5'h00, 16'h0, 2'h0, 2'h0, dmbx_pkg::FLAG_C);
			run(dmbx_pkg::OP_INDEXED_FLAG_CLEAR, 5'h00, 16'h0, 2'h0, 2'h0, dmbx_pkg::FLAG_H);
			run(ops[i], 5'h14, 16'h0, 2'h0, 2'h0, 3'h0);
			cyc(n, 1);
			cmp({status_flags_register[5], status_flags_register[3:0]}, fl[i]);
			rreg(5'h14);
			cmp(v, res[i]);
		end
		$display("shift test done");
	endtask
	// verdict
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#(25 * 20000);
		miscompares++;
		conclude;
	end
	// main sequence
	initial
	begin
		{cv, stall, rg, rfa, ad, md, pt, bt} = '0;
		op = dmbx_pkg::OP_IDLE_INSTR;
		sys_rst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_direct;
		t_ptr;
		t_misc;
		t_flags;
		t_shift;
		conclude;
	end
endmodule
`default_nettype wire
